// ---- verilog/supply_ctrl_pkg.sv ----
// constants shared by the supply and reset control logic
// assumes a single 100 MHz clock and synchronous active-high reset
package supply_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int FRAME_BITS = 16;
  localparam int IRQ_SRC = 8;
  // reset pulse lengths in microseconds
  localparam int RST_SHORT_US = 1;
  localparam int RST_LONG_US = 20;
  localparam int RST_SHORT_CYC = RST_SHORT_US * CLK_MHZ;
  localparam int RST_LONG_CYC = RST_LONG_US * CLK_MHZ;
  // least release time of the interrupt line after a read, ns, rounded up
  localparam int IRQ_GAP_NS = 2000;
  localparam int IRQ_GAP_CYC = (IRQ_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  // command frame layout: [15:12] command, [11:0] payload
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 12;
  localparam logic [3:0] CMD_CONTROL = 4'h1;
  localparam logic [3:0] CMD_IRQ_EN = 4'h2;
  localparam logic [3:0] CMD_IRQ_READ = 4'h3;
  localparam logic [3:0] CMD_WD_SERVE = 4'h4;
  localparam logic [3:0] CMD_SLEEP = 4'h5;
  // control payload bit positions
  localparam int BIT_CAN_SUP_ON = 0;
  localparam int BIT_INH_EN = 1;
  localparam int BIT_INH_VAL = 2;
  localparam int BIT_RST_LONG = 3;
  localparam int BIT_ERR_ON_EN = 4;
  localparam int BIT_ENABLE = 5;
  typedef enum logic [4:0] {
    MODE_START = 5'h01,
    MODE_NORMAL = 5'h02,
    MODE_SLEEP = 5'h04,
    MODE_RESTART = 5'h08,
    MODE_FAILSAFE = 5'h10
  } mode_type;
endpackage : supply_ctrl_pkg

// ---- verilog/frame_if.sv ----
// frame carrier between the serial receiver and the control core
// assumes one clock domain
`timescale 1ns/100ps
interface frame_if;
  logic frameValid;
  logic frameError;
  logic [15:0] frameData;
  modport source (output frameValid, output frameError, output frameData);
  modport sink (input frameValid, input frameError, input frameData);
endinterface : frame_if

// ---- verilog/spi_frame_rx.sv ----
// serial command receiver, one frame per chip-select low period
// assumes spi pins synchronous to ref_clk, sampled on rising sck
`timescale 1ns/100ps
module spi_frame_rx
  import supply_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spi_chip_select_n,
  input wire logic spiMosi,
  frame_if.source frm
);
  logic csPrev_reg;
  logic sckPrev_reg;
  logic [4:0] bitCnt_reg;
  logic [15:0] shift_reg;
  logic active_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csPrev_reg <= 1'b1;
      sckPrev_reg <= 1'b0;
    end else begin
      csPrev_reg <= spi_chip_select_n;
      sckPrev_reg <= spiClk;
    end
  end

  // any falling chip select opens a cycle; rising end checks the bit count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_reg <= 1'b0;
      bitCnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      frm.frameValid <= 1'b0;
      frm.frameError <= 1'b0;
      frm.frameData <= 16'h0000;
    end else begin
      frm.frameValid <= 1'b0;
      frm.frameError <= 1'b0;
      if (csPrev_reg && !spi_chip_select_n) begin
        active_reg <= 1'b1;
        bitCnt_reg <= 5'h00;
      end else if (active_reg && !spi_chip_select_n && spiClk && !sckPrev_reg) begin
        shift_reg <= {shift_reg[14:0], spiMosi};
        if (bitCnt_reg != 5'h1f) begin
          bitCnt_reg <= bitCnt_reg + 5'h01;
        end
      end else if (active_reg && !csPrev_reg && spi_chip_select_n) begin
        active_reg <= 1'b0;
        if (bitCnt_reg == 5'(FRAME_BITS)) begin
          frm.frameValid <= 1'b1;
          frm.frameData <= shift_reg;
        end else begin
          frm.frameError <= 1'b1;
        end
      end
    end
  end
endmodule : spi_frame_rx

// ---- verilog/pulse_timer.sv ----
// down counter giving a busy level for a loaded number of cycles
// assumes load pulses on ref_clk
`timescale 1ns/100ps
module pulse_timer
  import supply_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] length,
  output logic busy
);
  logic [CNT_W-1:0] count_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= length;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign busy = (count_reg != '0);
endmodule : pulse_timer

// ---- verilog/supply_reset_ctrl.sv ----
// supply, reset, interrupt and serial command control of the basis device
// assumes host pins synchronous to ref_clk; pads resolve the enables
`timescale 1ns/100ps
module supply_reset_ctrl
  import supply_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spi_chip_select_n,
  input wire logic spiMosi,
  output logic spiMiso,
  input wire logic watchdogTimeout,
  input wire logic wakeEvent,
  input wire logic resetRequest,
  input wire logic canActive,
  input wire logic canBusFailure,
  input wire logic [IRQ_SRC-1:0] irqSources,
  input wire logic [7:0] busFailureStatus,
  output logic system_reset_n,
  output logic irqOut,
  output logic irqOe,
  output logic supplyInhibitOut,
  output logic supplyInhibitOe,
  output logic mainRegulatorOn,
  output logic canSupplyRegulatorOn,
  output logic enableOut,
  output logic busBiasHalf,
  output logic failSafeActive
);
  import supply_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  frame_if frm ();
  mode_type mode_reg;
  logic [IRQ_SRC-1:0] irqEnable_reg;
  logic [IRQ_SRC-1:0] irqFlags_reg;
  logic [15:0] txShift_reg;
  logic canSupOn_reg;
  logic inhEn_reg;
  logic inhVal_reg;
  logic rstLong_reg;
  logic errOnEn_reg;
  logic enable_reg;
  logic rstLoad;
  logic rstBusy;
  logic gapLoad;
  logic gapBusy;
  logic [CNT_W-1:0] rstLen;
  logic cmdValid;
  logic [3:0] cmdCode;
  logic failEntry;
  logic sckPrev_reg;

  function automatic logic isCmd(input logic [15:0] data, input logic [3:0] code);
    isCmd = (data[CMD_HI:CMD_LO] == code);
  endfunction : isCmd

  spi_frame_rx rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .spiClk(spiClk),
    .spi_chip_select_n(spi_chip_select_n),
    .spiMosi(spiMosi),
    .frm(frm)
  );

  assign cmdValid = frm.frameValid;
  assign cmdCode = frm.frameData[CMD_HI:CMD_LO];
  // sleep has no watchdog to miss, so a stale timeout there must not force failsafe
  assign failEntry = watchdogTimeout && (mode_reg != MODE_FAILSAFE)
                     && (mode_reg != MODE_SLEEP);

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= MODE_START;
    end else begin
      unique case (mode_reg)
        MODE_START: begin
          if (failEntry) begin
            mode_reg <= MODE_FAILSAFE;
          end else if (!rstBusy) begin
            mode_reg <= MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          if (failEntry) begin
            mode_reg <= MODE_FAILSAFE;
          end else if (frm.frameError || resetRequest) begin
            mode_reg <= MODE_RESTART;
          end else if (cmdValid && cmdCode == CMD_SLEEP) begin
            mode_reg <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (wakeEvent) begin
            mode_reg <= MODE_RESTART;
          end
        end
        MODE_RESTART: begin
          if (failEntry) begin
            mode_reg <= MODE_FAILSAFE;
          end else if (!rstBusy && !rstLoad) begin
            mode_reg <= MODE_NORMAL;
          end
        end
        MODE_FAILSAFE: begin
          if (wakeEvent) begin
            mode_reg <= MODE_RESTART;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits written by host
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      canSupOn_reg <= 1'b0;
      inhEn_reg <= 1'b0;
      inhVal_reg <= 1'b0;
      rstLong_reg <= 1'b0;
      errOnEn_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      if (failEntry) begin
        inhEn_reg <= 1'b1;
        inhVal_reg <= 1'b0;
        enable_reg <= 1'b0;
      end else if (cmdValid && isCmd(frm.frameData, CMD_CONTROL)
                   && mode_reg == MODE_NORMAL && !watchdogTimeout) begin
        canSupOn_reg <= frm.frameData[BIT_CAN_SUP_ON];
        inhEn_reg <= frm.frameData[BIT_INH_EN];
        inhVal_reg <= frm.frameData[BIT_INH_VAL];
        rstLong_reg <= frm.frameData[BIT_RST_LONG];
        errOnEn_reg <= frm.frameData[BIT_ERR_ON_EN];
        enable_reg <= frm.frameData[BIT_ENABLE];
      end else if (!system_reset_n) begin
        enable_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset pulse generation
  assign rstLoad = (mode_reg == MODE_NORMAL && (frm.frameError || resetRequest))
                   || (mode_reg == MODE_SLEEP && wakeEvent)
                   || (mode_reg == MODE_FAILSAFE && wakeEvent)
                   || failEntry;
  // restart and failsafe get the long pulse, except a reset request with the long bit clear
  // the load cycle already drives reset low, so the timer runs one cycle less
  assign rstLen = (rstLong_reg || frm.frameError || resetRequest == 1'b0
                   || failEntry) ? CNT_W'(RST_LONG_CYC - 1)
                  : CNT_W'(RST_SHORT_CYC - 1);

  pulse_timer rstTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(rstLoad || (mode_reg == MODE_START && !rstBusy && rst)),
    .length(rstLen),
    .busy(rstBusy)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      system_reset_n <= 1'b0;
    end else begin
      system_reset_n <= !(rstBusy || rstLoad || mode_reg == MODE_START
                          || mode_reg == MODE_FAILSAFE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky flags, cleared on read, set wins
  assign gapLoad = cmdValid && cmdCode == CMD_IRQ_READ;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqEnable_reg <= '0;
      irqFlags_reg <= '0;
    end else begin
      if (cmdValid && cmdCode == CMD_IRQ_EN) begin
        irqEnable_reg <= frm.frameData[IRQ_SRC-1:0];
      end
      irqFlags_reg <= (gapLoad ? '0 : irqFlags_reg) | (irqSources & irqEnable_reg);
    end
  end

  pulse_timer gapTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(gapLoad),
    .length(CNT_W'(IRQ_GAP_CYC)),
    .busy(gapBusy)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqOe <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      irqOut <= 1'b0;
      irqOe <= (|irqFlags_reg) && !gapBusy && !gapLoad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read-back shift: bus failure status over flags, loaded at frame start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txShift_reg <= 16'h0000;
      sckPrev_reg <= 1'b0;
      spiMiso <= 1'b0;
    end else begin
      sckPrev_reg <= spiClk;
      if (spi_chip_select_n) begin
        txShift_reg <= {busFailureStatus, irqFlags_reg};
      end else if (!spiClk && sckPrev_reg) begin
        txShift_reg <= {txShift_reg[14:0], 1'b0};
      end
      spiMiso <= txShift_reg[15];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supplies, inhibit, enable and bias
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supplyInhibitOe <= 1'b0;
      supplyInhibitOut <= 1'b0;
      mainRegulatorOn <= 1'b0;
      canSupplyRegulatorOn <= 1'b0;
      enableOut <= 1'b0;
      busBiasHalf <= 1'b0;
      failSafeActive <= 1'b0;
    end else begin
      supplyInhibitOe <= inhEn_reg;
      supplyInhibitOut <= inhVal_reg && mode_reg != MODE_FAILSAFE && !failEntry;
      mainRegulatorOn <= !(mode_reg == MODE_SLEEP || mode_reg == MODE_FAILSAFE);
      canSupplyRegulatorOn <= canSupOn_reg || (canActive && mode_reg == MODE_NORMAL);
      enableOut <= errOnEn_reg ? !canBusFailure
                   : (enable_reg && system_reset_n);
      busBiasHalf <= (mode_reg == MODE_NORMAL) && canActive;
      failSafeActive <= (mode_reg == MODE_FAILSAFE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_fail_entry;
    failEntry;
  endsequence

  sequence s_ctrl_taken;
    cmdValid && cmdCode == CMD_CONTROL && mode_reg == MODE_NORMAL && !watchdogTimeout;
  endsequence

  a_rst_start: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == MODE_START |=> !system_reset_n)
    else $error("reset released during start");

  a_fail_rst: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == MODE_FAILSAFE |=> !system_reset_n)
    else $error("reset released in failsafe");

  a_long_pick: assert property (@(posedge ref_clk) disable iff (rst)
    (rstLoad && !resetRequest) |-> rstLen == CNT_W'(RST_LONG_CYC - 1))
    else $error("long reset not forced");

  a_short_pick: assert property (@(posedge ref_clk) disable iff (rst)
    (rstLoad && resetRequest && !rstLong_reg && !frm.frameError && !failEntry)
    |-> rstLen == CNT_W'(RST_SHORT_CYC - 1))
    else $error("short reset setting ignored");

  a_inh_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    s_ctrl_taken |-> ##2 (supplyInhibitOe == $past(frm.frameData[BIT_INH_EN], 2)))
    else $error("inhibit drive not taken from command");

  a_inh_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == MODE_SLEEP && inhEn_reg && inhVal_reg)
    |=> (supplyInhibitOe && supplyInhibitOut))
    else $error("inhibit dropped in sleep");

  a_miso_load: assert property (@(posedge ref_clk) disable iff (rst)
    spi_chip_select_n |=> txShift_reg == $past({busFailureStatus, irqFlags_reg}))
    else $error("read-back word not loaded");

  a_en_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (!system_reset_n && !errOnEn_reg) |=> !enableOut)
    else $error("enable high during reset");

  a_main_fail: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == MODE_FAILSAFE |=> !mainRegulatorOn)
    else $error("main regulator on in failsafe");

  a_gap_start: assert property (@(posedge ref_clk) disable iff (rst)
    gapLoad |=> gapBusy)
    else $error("release timer not started by read");

  a_inh_fail_low: assert property (@(posedge ref_clk) disable iff (rst)
    s_fail_entry |-> ##2 (supplyInhibitOe && !supplyInhibitOut))
    else $error("inhibit not low after failsafe entry");
  a_fail_mode: assert property (@(posedge ref_clk) disable iff (rst)
    s_fail_entry |=> mode_reg == MODE_FAILSAFE)
    else $error("failsafe not entered");
  a_rst_on_err: assert property (@(posedge ref_clk) disable iff (rst)
    (frm.frameError && mode_reg == MODE_NORMAL) |-> ##1 !system_reset_n)
    else $error("no reset after bad frame");
  a_irq_gap: assert property (@(posedge ref_clk) disable iff (rst)
    gapLoad |=> !irqOe [*8])
    else $error("irq asserted too soon after read");
  a_main_reg: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == MODE_SLEEP |=> !mainRegulatorOn)
    else $error("main regulator on in sleep");
  a_can_sup: assert property (@(posedge ref_clk) disable iff (rst)
    canSupOn_reg |=> canSupplyRegulatorOn)
    else $error("can supply off while forced on");
  a_bias_low: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == MODE_SLEEP |=> !busBiasHalf)
    else $error("bias not grounded in low power");
  a_irq_mask: assert property (@(posedge ref_clk) disable iff (rst)
    (irqFlags_reg == '0 && $past(irqFlags_reg) == '0) |=> !irqOe)
    else $error("irq without enabled source");
  a_err_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (errOnEn_reg && canBusFailure) |=> !enableOut)
    else $error("error not shown on enable pin");
  a_power_float: assert property (@(posedge ref_clk)
    $fell(rst) |-> !supplyInhibitOe)
    else $error("inhibit driven after power-on");
endmodule : supply_reset_ctrl

// ---- dv/host_mcu_model.sv ----
// host controller model: drives command frames on the serial pins
// assumes the bench calls xfer only while the system reset line is high
`timescale 1ns/100ps
module host_mcu_model #(
  parameter int HALF = 2
) (
  input wire logic ref_clk,
  input wire logic spiMiso,
  output logic spiClk,
  output logic spi_chip_select_n,
  output logic spiMosi
);
  initial begin
    spiClk = 1'b0;
    spi_chip_select_n = 1'b1;
    spiMosi = 1'b0;
  end
  // chip select only ever falls here, so no stray frame start reaches the device
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge ref_clk);
    spi_chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spiMosi = word[15-i];
      repeat (HALF) @(negedge ref_clk);
      spiClk = 1'b1;
      rx = {rx[14:0], spiMiso};
      repeat (HALF) @(negedge ref_clk);
      spiClk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    spi_chip_select_n = 1'b1;
    // data line is not held after the frame
    spiMosi = ~spiMosi;
    repeat (6) @(negedge ref_clk);
  endtask : xfer
endmodule : host_mcu_model

// ---- dv/supply_reset_ctrl_tb.sv ----
// self-checking bench of the supply and reset control block
// assumes the host model drives the serial pins; pads resolved here
`timescale 1ns/100ps
module supply_reset_ctrl_tb;
  import supply_ctrl_pkg::*;
  logic ref_clk, rst, watchdogTimeout, wakeEvent, resetRequest, canActive, canBusFailure;
  logic [IRQ_SRC-1:0] irqSources, mask;
  logic [7:0] busFailureStatus;
  logic spiClk, spi_chip_select_n, spiMosi, spiMiso, system_reset_n, irqOut, irqOe;
  logic supplyInhibitOut, supplyInhibitOe, mainRegulatorOn, canSupplyRegulatorOn;
  logic enableOut, busBiasHalf, failSafeActive;
  logic [15:0] rx;
  logic [5:0] ctl;
  int n_fail = 0;
  int checks = 0;
  int lowCnt = 0;
  int lastLow = 0;
  int bad;
  // pull-down on the inhibit pin
  wire inhLine = supplyInhibitOe ? supplyInhibitOut : 1'b0;
  supply_reset_ctrl supply_reset_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .spiClk(spiClk), .spi_chip_select_n(spi_chip_select_n),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .watchdogTimeout(watchdogTimeout),
    .wakeEvent(wakeEvent), .resetRequest(resetRequest), .canActive(canActive),
    .canBusFailure(canBusFailure), .irqSources(irqSources),
    .busFailureStatus(busFailureStatus), .system_reset_n(system_reset_n),
    .irqOut(irqOut), .irqOe(irqOe), .supplyInhibitOut(supplyInhibitOut),
    .supplyInhibitOe(supplyInhibitOe), .mainRegulatorOn(mainRegulatorOn),
    .canSupplyRegulatorOn(canSupplyRegulatorOn), .enableOut(enableOut),
    .busBiasHalf(busBiasHalf), .failSafeActive(failSafeActive)
  );
  host_mcu_model host_mcu_model_inst (
    .ref_clk(ref_clk), .spiMiso(spiMiso), .spiClk(spiClk),
    .spi_chip_select_n(spi_chip_select_n), .spiMosi(spiMosi)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // length of the latest low pulse on the reset line
  always @(posedge ref_clk) begin
    if (system_reset_n === 1'b0) lowCnt <= lowCnt + 1;
    else if (lowCnt != 0) begin
      lastLow <= lowCnt;
      lowCnt <= 0;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic wait_up();
    for (int k = 0; k < 3000 && system_reset_n !== 1'b1; k++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    chk("reset released", 16'h1, 16'(system_reset_n));
  endtask : wait_up
  task automatic send(input logic [3:0] cmd, input logic [11:0] pay);
    host_mcu_model_inst.xfer({cmd, pay}, 16, rx);
  endtask : send
  function automatic logic exp_en(input logic [5:0] c);
    return c[BIT_ERR_ON_EN] ? ~canBusFailure : c[BIT_ENABLE];
  endfunction : exp_en
  task automatic chk_ctrl(input logic [5:0] c);
    chk("can supply", 16'(c[BIT_CAN_SUP_ON]), 16'(canSupplyRegulatorOn));
    chk("inhibit oe", 16'(c[BIT_INH_EN]), 16'(supplyInhibitOe));
    if (c[BIT_INH_EN]) chk("inhibit", 16'(c[BIT_INH_VAL]), 16'(inhLine));
    chk("enable", 16'(exp_en(c)), 16'(enableOut));
  endtask : chk_ctrl
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // whole run is some 10k cycles
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
  initial begin
    {rst, watchdogTimeout, wakeEvent, resetRequest, canActive, canBusFailure} = 6'h20;
    irqSources = 8'h00;
    busFailureStatus = 8'h00;
    void'($urandom(32'ha12c));
    repeat (5) @(negedge ref_clk);
    chk("inhibit float", 16'h0, 16'(supplyInhibitOe));
    chk("reset low", 16'h0, 16'(system_reset_n));
    rst = 1'b0;
    wait_up();
    chk("float after start", 16'h0, 16'(supplyInhibitOe));
    chk("main reg on", 16'h1, 16'(mainRegulatorOn));
    canActive = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("bias normal", 16'h1, 16'(busBiasHalf));
    canActive = 1'b0;
    repeat (3) @(negedge ref_clk);
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      ctl = 6'($urandom());
      canBusFailure = 1'($urandom());
      send(CMD_CONTROL, 12'(ctl));
      chk_ctrl(ctl);
      send(CMD_WD_SERVE, 12'h000);
    end
    $display("test control done");
    send(CMD_CONTROL, 12'h006);
    send(CMD_SLEEP, 12'h000);
    chk("sleep main reg", 16'h0, 16'(mainRegulatorOn));
    chk("sleep inhibit", 16'h1, 16'(inhLine));
    chk("sleep bias", 16'h0, 16'(busBiasHalf));
    wakeEvent = 1'b1;
    @(negedge ref_clk);
    wakeEvent = 1'b0;
    wait_up();
    chk("wake main reg", 16'h1, 16'(mainRegulatorOn));
    $display("test sleep done");
    for (int i = 0; i < 2; i++) begin
      send(CMD_CONTROL, 12'(i << BIT_RST_LONG));
      resetRequest = 1'b1;
      @(negedge ref_clk);
      resetRequest = 1'b0;
      wait_up();
      chk("reset length", 16'(i ? RST_LONG_CYC : RST_SHORT_CYC), 16'(lastLow));
    end
    send(CMD_CONTROL, 12'h000);
    host_mcu_model_inst.xfer(16'h1000, 15, rx);
    chk("serial fault reset", 16'h0, 16'(system_reset_n));
    wait_up();
    chk("restart length", 16'(RST_LONG_CYC), 16'(lastLow));
    $display("test reset done");
    mask = 8'($urandom()) | 8'h01;
    send(CMD_IRQ_EN, 12'(mask));
    irqSources = 8'($urandom()) & ~mask;
    repeat (4) @(negedge ref_clk);
    chk("irq masked", 16'h0, 16'(irqOe));
    irqSources = irqSources | (mask & ~(mask - 8'h01));
    busFailureStatus = 8'($urandom());
    repeat (4) @(negedge ref_clk);
    chk("irq active", 16'h1, 16'(irqOe));
    chk("irq line low", 16'h0, 16'(irqOut));
    send(CMD_IRQ_READ, 12'h000);
    chk("failure status", 16'(busFailureStatus), 16'(rx[15:8]));
    bad = 0;
    repeat (IRQ_GAP_CYC - 20) begin
      @(negedge ref_clk);
      if (irqOe !== 1'b0) bad++;
    end
    chk("irq gap", 16'h0, 16'(bad));
    for (int k = 0; k < 40 && irqOe !== 1'b1; k++) @(negedge ref_clk);
    chk("irq again", 16'h1, 16'(irqOe));
    $display("test irq done");
    send(CMD_CONTROL, 12'h006);
    watchdogTimeout = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk("failsafe", 16'h1, 16'(failSafeActive));
    chk("limp oe", 16'h1, 16'(supplyInhibitOe));
    chk("limp low", 16'h0, 16'(supplyInhibitOut));
    chk("failsafe main reg", 16'h0, 16'(mainRegulatorOn));
    watchdogTimeout = 1'b0;
    wakeEvent = 1'b1;
    @(negedge ref_clk);
    wakeEvent = 1'b0;
    wait_up();
    $display("test failsafe done");
    close_out();
  end
endmodule : supply_reset_ctrl_tb
